// ===== common/rre_pkg.sv
// Shared constants and types of the rotate and return execution block.
// Assumes an 8-bit register file with control registers at the top of its map.
//
// Operation
// - Carry clear forces C to zero only.
// - Return loads PC from stack, takes 14.
// - Return adds two to stack pointer.
// - High PC byte first, low byte next.
// - Rotate left opcodes 90/91, six cycles.
// - Rotate left: bit 7 to bit 0, C.
// - Rotate via carry: 10/11, through C.
// - Rotate right opcodes E0/E1, six cycles.
// - Rotate right: bit 0 to bit 7, C.
// - Zero flag set when result is zero.
// - Sign flag equals result bit seven.
// - Overflow set when bit seven changes.
// - High nibble 1110b selects a working register.
// - Indirect mode reads pointer, rotates pointed register.
// - Stack pointer held at FEh and FFh.
// - Flags held at register file address FCh.
package rre_pkg;

  // ----------------------------------------------------------------
  // Opcodes (on the rotates, bit 0 set selects the indirect operand)
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_CLEAR_CARRY = 8'hCF;
  localparam logic [7:0] OPC_SUB_EXIT = 8'hAF;
  localparam logic [7:0] OPC_ROT_LEFT = 8'h90;
  localparam logic [7:0] OPC_ROT_LEFT_CARRY = 8'h10;
  localparam logic [7:0] OPC_ROT_RIGHT = 8'hE0;
  localparam logic [3:0] WORK_REG_NIBBLE = 4'hE;

  // ----------------------------------------------------------------
  // Register file addresses and flag layout
  // ----------------------------------------------------------------
  localparam logic [7:0] RF_FLAGS_ADDR = 8'hFC;
  localparam logic [7:0] RF_RP_ADDR = 8'hFD;
  localparam logic [7:0] RF_SP_HI_ADDR = 8'hFE;
  localparam logic [7:0] RF_SP_LO_ADDR = 8'hFF;
  localparam int FLAG_C_POS = 7;
  localparam int FLAG_Z_POS = 6;
  localparam int FLAG_S_POS = 5;
  localparam int FLAG_V_POS = 4;
  localparam int FLAG_D_POS = 3;
  localparam int FLAG_H_POS = 2;
  localparam logic [15:0] SP_NEXT_BYTE = 16'h0001;
  localparam logic [15:0] SP_POP_STEP = 16'h0002;

  // ----------------------------------------------------------------
  // Instruction lengths in clock cycles
  // ----------------------------------------------------------------
  localparam logic [4:0] CYC_CLEAR_CARRY = 5'h06;
  localparam logic [4:0] CYC_SUB_EXIT = 5'h0E;
  localparam logic [4:0] CYC_ROTATE = 5'h06;

  // ----------------------------------------------------------------
  // APB register map and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_PC = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam int ST_BUSY_POS = 0;
  localparam int ST_DONE_POS = 1;
  localparam int ST_ILLEGAL_POS = 2;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  typedef enum logic [1:0] {ROT_LEFT, ROT_LEFT_CARRY, ROT_RIGHT} rre_rot_t;

endpackage

// ===== rtl/rre_rotate_unit.sv
// Combinational one-bit rotator with its flag results.
// Assumes the caller merges the flags into the flag register.
`timescale 1ns/1ps
module rre_rotate_unit (
  input rre_pkg::rre_rot_t kind,
  input logic [7:0] din,
  input logic cin,
  output logic [7:0] dout,
  output logic cout,
  output logic zero,
  output logic sign,
  output logic ovf
);
  wire is_right = (kind == rre_pkg::ROT_RIGHT);
  wire fill_left = (kind == rre_pkg::ROT_LEFT_CARRY) ? cin : din[7];

  assign dout = is_right ? {din[0], din[7:1]} : {din[6:0], fill_left};
  assign cout = is_right ? din[0] : din[7];
  assign zero = (dout == 8'h00);
  assign sign = dout[7];
  assign ovf = dout[7] ^ din[7];
endmodule

// ===== rtl/rre_operand_decode.sv
// Operand byte to register file address, including working registers.
// Assumes the register pointer value is presented by the caller.
`timescale 1ns/1ps
module rre_operand_decode (
  input logic [7:0] operand,
  input logic [7:0] rp,
  output logic [7:0] reg_addr,
  output logic working
);
  // The pointer's high nibble names the group of sixteen working registers.
  assign working = (operand[7:4] == rre_pkg::WORK_REG_NIBBLE);
  assign reg_addr = working ? {rp[7:4], operand[3:0]} : operand;
endmodule

// ===== rtl/rre_exec.sv
// Execution sequencer for carry clear, return and the three rotates.
// Assumes register file and stack memory reads return data in the same
// cycle as the address, and writes take effect at the clock edge.
`timescale 1ns/1ps
module rre_exec (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] rf_addr,
  output logic rf_re,
  output logic rf_we,
  output logic [7:0] rf_wdata,
  input logic [7:0] rf_rdata,
  output logic [15:0] stk_addr,
  output logic stk_re,
  input logic [7:0] stk_rdata,
  output logic [15:0] pc,
  output logic pc_load,
  output logic busy
);

  // ----------------------------------------------------------------
  // Types and state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_RP, S_PTR, S_IND, S_FLG, S_WR, S_WFL, S_CR, S_CW,
    S_SPH, S_SPL, S_STK0, S_STK1, S_WSPH, S_WSPL, S_PAD
  } rre_state_t;

  rre_state_t state;
  rre_state_t next_state;
  logic [7:0] opcode_q;
  logic [7:0] operand_q;
  rre_pkg::rre_rot_t kind_q;
  logic indirect_q;
  logic [4:0] limit_q;
  logic [4:0] cnt_q;
  logic [7:0] dst_addr_q;
  logic [7:0] dst_val_q;
  logic [7:0] new_flags_q;
  logic [7:0] sp_hi_q;
  logic [15:0] sp_q;
  logic [7:0] pc_hi_q;
  logic [7:0] pc_lo_q;
  logic [7:0] flags_view;
  logic done_q;
  logic illegal_q;
  logic [7:0] next_rf_addr;
  logic next_rf_re;
  logic next_rf_we;
  logic [7:0] next_rf_wdata;
  logic [15:0] next_stk_addr;
  logic next_stk_re;
  logic [7:0] next_flags_rot;
  logic [7:0] next_flags_clr;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite;
  wire hit_cmd = (paddr == rre_pkg::ADDR_CMD);
  wire hit_status = (paddr == rre_pkg::ADDR_STATUS);
  wire hit_pc = (paddr == rre_pkg::ADDR_PC);
  wire hit_flags = (paddr == rre_pkg::ADDR_FLAGS);
  wire mapped = hit_cmd | hit_status | hit_pc | hit_flags;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign busy = (state != S_IDLE);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire [7:0] new_opc = pwdata[7:0];
  wire [7:0] new_base = {new_opc[7:1], 1'b0};
  wire is_clr = (new_opc == rre_pkg::OPC_CLEAR_CARRY);
  wire is_exit = (new_opc == rre_pkg::OPC_SUB_EXIT);
  wire is_rot_l = (new_base == rre_pkg::OPC_ROT_LEFT);
  wire is_rot_lc = (new_base == rre_pkg::OPC_ROT_LEFT_CARRY);
  wire is_rot_r = (new_base == rre_pkg::OPC_ROT_RIGHT);
  wire legal = is_clr | is_exit | is_rot_l | is_rot_lc | is_rot_r;
  wire cmd_write = apb_wr & hit_cmd & ~busy;
  wire accept = cmd_write & legal;
  wire reject = cmd_write & ~legal;
  wire last = (cnt_q == limit_q);
  wire finish = busy & last;
  wire clr_done = apb_wr & hit_status & pwdata[rre_pkg::ST_DONE_POS];
  wire clr_illegal = apb_wr & hit_status & pwdata[rre_pkg::ST_ILLEGAL_POS];
  wire [15:0] sp_plus2 = sp_q + rre_pkg::SP_POP_STEP;
  wire [15:0] sp_plus1 = sp_q + rre_pkg::SP_NEXT_BYTE;
  wire [15:0] sp_now = {sp_hi_q, rf_rdata};

  rre_pkg::rre_rot_t new_kind;
  assign new_kind = is_rot_r ? rre_pkg::ROT_RIGHT :
                    is_rot_lc ? rre_pkg::ROT_LEFT_CARRY : rre_pkg::ROT_LEFT;
  wire [4:0] new_limit = is_exit ? rre_pkg::CYC_SUB_EXIT - 5'h01 :
                         is_clr ? rre_pkg::CYC_CLEAR_CARRY - 5'h01 :
                         rre_pkg::CYC_ROTATE - 5'h01;

  // ----------------------------------------------------------------
  // Datapath helpers
  // ----------------------------------------------------------------
  wire [7:0] dec_addr;
  wire [7:0] rot_dout;
  wire rot_cout;
  wire rot_zero;
  wire rot_sign;
  wire rot_ovf;

  // The pointer value arrives on the read port in S_PTR only.
  rre_operand_decode u_decode (
    .operand(operand_q),
    .rp(rf_rdata),
    .reg_addr(dec_addr),
    .working()
  );

  rre_rotate_unit u_rotate (
    .kind(kind_q),
    .din(dst_val_q),
    .cin(rf_rdata[rre_pkg::FLAG_C_POS]),
    .dout(rot_dout),
    .cout(rot_cout),
    .zero(rot_zero),
    .sign(rot_sign),
    .ovf(rot_ovf)
  );

  // Only C, Z, S and V are replaced, so D and H pass through untouched.
  always_comb begin
    next_flags_rot = rf_rdata;
    next_flags_rot[rre_pkg::FLAG_C_POS] = rot_cout;
    next_flags_rot[rre_pkg::FLAG_Z_POS] = rot_zero;
    next_flags_rot[rre_pkg::FLAG_S_POS] = rot_sign;
    next_flags_rot[rre_pkg::FLAG_V_POS] = rot_ovf;
    next_flags_clr = rf_rdata;
    next_flags_clr[rre_pkg::FLAG_C_POS] = 1'b0;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Port requests are registered, so a read issued in one state is
  // answered on rf_rdata or stk_rdata in the state that follows.
  always_comb begin
    next_state = state;
    next_rf_addr = rf_addr;
    next_rf_re = 1'b0;
    next_rf_we = 1'b0;
    next_rf_wdata = rf_wdata;
    next_stk_addr = stk_addr;
    next_stk_re = 1'b0;
    case (state)
      S_IDLE: begin
        if (accept) begin
          next_state = is_exit ? S_SPH : (is_clr ? S_CR : S_RP);
        end
      end
      S_RP: begin
        next_rf_addr = rre_pkg::RF_RP_ADDR;
        next_rf_re = 1'b1;
        next_state = S_PTR;
      end
      S_PTR: begin
        next_rf_addr = dec_addr;
        next_rf_re = 1'b1;
        next_state = indirect_q ? S_IND : S_FLG;
      end
      S_IND: begin
        next_rf_addr = rf_rdata;
        next_rf_re = 1'b1;
        next_state = S_FLG;
      end
      S_FLG: begin
        next_rf_addr = rre_pkg::RF_FLAGS_ADDR;
        next_rf_re = 1'b1;
        next_state = S_WR;
      end
      S_WR: begin
        next_rf_addr = dst_addr_q;
        next_rf_we = 1'b1;
        next_rf_wdata = rot_dout;
        next_state = S_WFL;
      end
      S_WFL: begin
        next_rf_addr = rre_pkg::RF_FLAGS_ADDR;
        next_rf_we = 1'b1;
        next_rf_wdata = new_flags_q;
        next_state = last ? S_IDLE : S_PAD;
      end
      S_CR: begin
        next_rf_addr = rre_pkg::RF_FLAGS_ADDR;
        next_rf_re = 1'b1;
        next_state = S_CW;
      end
      S_CW: begin
        next_rf_addr = rre_pkg::RF_FLAGS_ADDR;
        next_rf_we = 1'b1;
        next_rf_wdata = next_flags_clr;
        next_state = S_PAD;
      end
      S_SPH: begin
        next_rf_addr = rre_pkg::RF_SP_HI_ADDR;
        next_rf_re = 1'b1;
        next_state = S_SPL;
      end
      S_SPL: begin
        next_rf_addr = rre_pkg::RF_SP_LO_ADDR;
        next_rf_re = 1'b1;
        next_state = S_STK0;
      end
      S_STK0: begin
        next_stk_addr = sp_now;
        next_stk_re = 1'b1;
        next_state = S_STK1;
      end
      S_STK1: begin
        next_stk_addr = sp_plus1;
        next_stk_re = 1'b1;
        next_state = S_WSPH;
      end
      S_WSPH: begin
        next_rf_addr = rre_pkg::RF_SP_HI_ADDR;
        next_rf_we = 1'b1;
        next_rf_wdata = sp_plus2[15:8];
        next_state = S_WSPL;
      end
      S_WSPL: begin
        next_rf_addr = rre_pkg::RF_SP_LO_ADDR;
        next_rf_we = 1'b1;
        next_rf_wdata = sp_plus2[7:0];
        next_state = S_PAD;
      end
      S_PAD: begin
        next_state = last ? S_IDLE : S_PAD;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      cnt_q <= 5'h00;
      rf_addr <= 8'h00;
      rf_re <= 1'b0;
      rf_we <= 1'b0;
      rf_wdata <= 8'h00;
      stk_addr <= 16'h0000;
      stk_re <= 1'b0;
    end else begin
      state <= next_state;
      cnt_q <= accept ? 5'h00 : (busy ? cnt_q + 5'h01 : cnt_q);
      rf_addr <= next_rf_addr;
      rf_re <= next_rf_re;
      rf_we <= next_rf_we;
      rf_wdata <= next_rf_wdata;
      stk_addr <= next_stk_addr;
      stk_re <= next_stk_re;
    end
  end

  // ----------------------------------------------------------------
  // Operand and return capture
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode_q <= 8'h00;
      operand_q <= 8'h00;
      kind_q <= rre_pkg::ROT_LEFT;
      indirect_q <= 1'b0;
      limit_q <= 5'h00;
    end else if (accept) begin
      opcode_q <= new_opc;
      operand_q <= pwdata[15:8];
      kind_q <= new_kind;
      indirect_q <= new_opc[0];
      limit_q <= new_limit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst_addr_q <= 8'h00;
      dst_val_q <= 8'h00;
      new_flags_q <= rre_pkg::FLAGS_RESET;
      sp_hi_q <= 8'h00;
      sp_q <= 16'h0000;
      pc_hi_q <= 8'h00;
      pc_lo_q <= 8'h00;
    end else begin
      if (state == S_PTR) dst_addr_q <= dec_addr;
      if (state == S_IND) dst_addr_q <= rf_rdata;
      if (state == S_FLG) dst_val_q <= rf_rdata;
      if (state == S_WR) new_flags_q <= next_flags_rot;
      if (state == S_SPL) sp_hi_q <= rf_rdata;
      if (state == S_STK0) sp_q <= sp_now;
      if (state == S_STK1) pc_hi_q <= stk_rdata;
      if (state == S_WSPH) pc_lo_q <= stk_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Program counter, status and read data
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc <= rre_pkg::PC_RESET;
      pc_load <= 1'b0;
      flags_view <= rre_pkg::FLAGS_RESET;
      done_q <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      pc_load <= (state == S_WSPL);
      if (state == S_WSPL) begin
        pc <= {pc_hi_q, pc_lo_q};
      end else if (apb_wr & hit_pc & ~busy) begin
        pc <= pwdata[15:0];
      end
      if (rf_we && rf_addr == rre_pkg::RF_FLAGS_ADDR) flags_view <= rf_wdata;
      // A completion or refusal in the clearing cycle stays visible.
      done_q <= finish | (done_q & ~clr_done);
      illegal_q <= reject | (illegal_q & ~clr_illegal);
    end
  end

  wire [31:0] read_value =
    hit_cmd ? {16'h0000, operand_q, opcode_q} :
    hit_status ? {29'h0000_0000, illegal_q, done_q, busy} :
    hit_pc ? {16'h0000, pc} :
    hit_flags ? {24'h00_0000, flags_view} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup & ~pwrite) begin
      prdata <= read_value;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] run_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_len <= 5'h00;
    else if (accept) run_len <= 5'h00;
    else if (busy) run_len <= run_len + 5'h01;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence seq_pop_hi;
    stk_re && stk_addr == sp_q;
  endsequence
  sequence seq_pop_lo;
    stk_re && stk_addr == sp_q + 16'h0001;
  endsequence
  sequence seq_sp_write;
    (rf_we && rf_addr == 8'hFE && rf_wdata == sp_plus2[15:8])
      ##1 (rf_we && rf_addr == 8'hFF && rf_wdata == sp_plus2[7:0]);
  endsequence

  chk_carry_clear:
    assert property (state == S_CW |=> rf_we && rf_addr == rre_pkg::RF_FLAGS_ADDR &&
      rf_wdata == ($past(rf_rdata) & 8'h7F)) else $error("carry clear wrote bad flags");
  chk_exit_cycle_count:
    assert property ($fell(busy) && opcode_q == rre_pkg::OPC_SUB_EXIT |->
      run_len == rre_pkg::CYC_SUB_EXIT) else $error("return did not take fourteen cycles");
  chk_rot_cycle_count:
    assert property ($fell(busy) && opcode_q != rre_pkg::OPC_SUB_EXIT |->
      run_len == rre_pkg::CYC_ROTATE) else $error("rotate or clear did not take six cycles");
  chk_pop_byte_order:
    assert property (state == S_STK1 |-> seq_pop_hi ##1 seq_pop_lo)
    else $error("stack bytes read in wrong order");
  chk_sp_plus_two:
    assert property (state == S_WSPH |=> seq_sp_write)
    else $error("stack pointer not advanced by two");
  chk_pc_from_stack:
    assert property (state == S_WSPL |=> pc_load &&
      pc == {$past(stk_rdata, 3), $past(stk_rdata, 2)}) else $error("pc not loaded from stack");
  chk_left_result:
    assert property (state == S_WR && kind_q == rre_pkg::ROT_LEFT |=>
      rf_wdata == {$past(dst_val_q[6:0]), $past(dst_val_q[7])}) else $error("rotate left wrong");
  chk_carry_rot_result:
    assert property (state == S_WR && kind_q == rre_pkg::ROT_LEFT_CARRY |=>
      rf_wdata == {$past(dst_val_q[6:0]), $past(rf_rdata[7])}) else $error("rotate carry wrong");
  chk_right_result:
    assert property (state == S_WR && kind_q == rre_pkg::ROT_RIGHT |=>
      rf_wdata == {$past(dst_val_q[0]), $past(dst_val_q[7:1])}) else $error("rotate right wrong");
  chk_rot_flag_update:
    assert property (state == S_WFL |=> rf_we && rf_addr == 8'hFC &&
      rf_wdata[6] == ($past(rf_wdata) == 8'h00) && rf_wdata[5] == $past(rf_wdata[7]) &&
      rf_wdata[4] == ($past(rf_wdata[7]) != dst_val_q[7]) &&
      rf_wdata[3:2] == $past(rf_rdata[3:2], 2)) else $error("rotate flags wrong");
  chk_exit_keeps_flags:
    assert property (busy && opcode_q == rre_pkg::OPC_SUB_EXIT |->
      !(rf_we && rf_addr == rre_pkg::RF_FLAGS_ADDR))
    else $error("return touched the flags");
  chk_work_reg_addr:
    assert property (state == S_PTR && operand_q[7:4] == 4'hE |=>
      rf_addr == {$past(rf_rdata[7:4]), operand_q[3:0]}) else $error("working register wrong");
  chk_ptr_follow:
    assert property (state == S_IND |=> rf_re && rf_addr == $past(rf_rdata) ##2
      rf_we && rf_addr == $past(rf_rdata, 3)) else $error("indirect target wrong");

endmodule

// ===== tb/rre_mem_model.sv
// Behavioural register file and stack memory on the far side of rre_exec.
// Assumes the bench preloads both arrays before each instruction starts.
`timescale 1ns/1ps
module rre_mem_model (
  input logic pclk,
  input logic [7:0] rf_addr,
  input logic rf_re,
  input logic rf_we,
  input logic [7:0] rf_wdata,
  output logic [7:0] rf_rdata,
  input logic [15:0] stk_addr,
  input logic stk_re,
  output logic [7:0] stk_rdata
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] rf [0:255];
  logic [7:0] stk [0:65535];
  // Without a read strobe the lines show inverted data, so a late sample fails.
  assign rf_rdata = rf_re ? rf[rf_addr] : ~rf[rf_addr];
  assign stk_rdata = stk_re ? stk[stk_addr] : ~stk[stk_addr];
  always @(posedge pclk) begin
    if (rf_we) begin
      rf[rf_addr] <= rf_wdata;
    end
  end
endmodule

// ===== tb/rre_exec_tb.sv
// Self-checking bench of the rotate and return block through its APB port.
// Assumes rre_mem_model stands in for the register file and the stack.
`timescale 1ns/1ps
module rre_exec_tb;
  localparam logic [7:0] RP = 8'h70;
  localparam logic [7:0] FC = rre_pkg::RF_FLAGS_ADDR;
  localparam logic [7:0] FE = rre_pkg::RF_SP_HI_ADDR;
  localparam logic [7:0] FF = rre_pkg::RF_SP_LO_ADDR;
  localparam logic [7:0] A_ST = rre_pkg::ADDR_STATUS;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] rf_addr;
  logic rf_re;
  logic rf_we;
  logic [7:0] rf_wdata;
  logic [7:0] rf_rdata;
  logic [15:0] stk_addr;
  logic stk_re;
  logic [7:0] stk_rdata;
  logic [15:0] pc;
  logic pc_load;
  logic busy;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;

  rre_exec dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rf_addr, .rf_re, .rf_we, .rf_wdata, .rf_rdata,
    .stk_addr, .stk_re, .stk_rdata, .pc, .pc_load, .busy);
  rre_mem_model m (.pclk, .rf_addr, .rf_re, .rf_we, .rf_wdata, .rf_rdata,
    .stk_addr, .stk_re, .stk_rdata);

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  // A full run takes about 400 cycles; the ceiling leaves wide margin.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [15:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd[15:0], exp);
  endtask

  task exec(input logic [7:0] opc, input logic [7:0] opd, input int n_exp, input int pl_exp);
    int n;
    int pl;
    n = 0;
    pl = 0;
    apb(1'b1, rre_pkg::ADDR_CMD, {16'h0000, opd, opc});
    // Sampled mid-cycle, where busy and pc_load have settled.
    repeat (20) begin
      @(negedge pclk);
      if (busy === 1'b1) n++;
      if (pc_load === 1'b1) pl++;
    end
    chk(16'(n), 16'(n_exp));
    chk(16'(pl), 16'(pl_exp));
    rdc(A_ST, 16'h0002);
    apb(1'b1, A_ST, 32'h0000_0006);
  endtask

  task rot(input logic [7:0] opc, opd, dat, input logic cin, input logic [7:0] res);
    logic [7:0] a;
    logic [7:0] f;
    a = (opd[7:4] == rre_pkg::WORK_REG_NIBBLE) ? {RP[7:4], opd[3:0]} : opd;
    if (opc[0]) begin
      m.rf[a] = 8'h31;
      a = 8'h31;
    end
    m.rf[a] = dat;
    m.rf[FC] = {cin, 7'h5d};
    f = {(opc[7:4] == 4'he) ? dat[0] : dat[7], res == 8'h00, res[7], res[7] ^ dat[7], 4'hd};
    exec(opc, opd, 6, 0);
    chk(16'(m.rf[a]), 16'(res));
    chk(16'(m.rf[FC]), 16'(f));
    rdc(rre_pkg::ADDR_FLAGS, 16'(f));
    rdc(rre_pkg::ADDR_CMD, {opd, opc});
  endtask

  task sub_exit(input logic [15:0] sp, input logic [7:0] hi, input logic [7:0] lo);
    m.rf[FE] = sp[15:8];
    m.rf[FF] = sp[7:0];
    m.stk[sp] = hi;
    m.stk[sp + 16'h0001] = lo;
    m.rf[FC] = 8'ha5;
    exec(rre_pkg::OPC_SUB_EXIT, 8'h00, 14, 1);
    chk(pc, {hi, lo});
    chk({m.rf[FE], m.rf[FF]}, sp + 16'h0002);
    chk(16'(m.rf[FC]), 16'h00a5);
    rdc(rre_pkg::ADDR_PC, {hi, lo});
  endtask

  task end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    m.rf[rre_pkg::RF_RP_ADDR] = RP;
    rdc(A_ST, 16'h0000);
    rdc(rre_pkg::ADDR_PC, rre_pkg::PC_RESET);
    rdc(rre_pkg::ADDR_FLAGS, 16'(rre_pkg::FLAGS_RESET));
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(16'(er), 16'h0001);
    chk(rd[15:0], 16'h0000);
    apb(1'b1, rre_pkg::ADDR_CMD, 32'h0000_0000);
    rdc(A_ST, 16'h0004);
    apb(1'b1, A_ST, 32'h0000_0006);
    $display("test reset and refusals finished");
    rot(8'h90, 8'hc6, 8'h88, 1'b0, 8'h11);
    rot(8'h91, 8'hc6, 8'h44, 1'b1, 8'h88);
    rot(8'h90, 8'h40, 8'h00, 1'b1, 8'h00);
    rot(8'h10, 8'hc6, 8'h8f, 1'b0, 8'h1e);
    rot(8'h11, 8'he4, 8'h8f, 1'b1, 8'h1f);
    rot(8'he0, 8'he6, 8'h31, 1'b0, 8'h98);
    rot(8'he1, 8'hc6, 8'h7e, 1'b1, 8'h3f);
    $display("test rotates finished");
    m.rf[FC] = 8'hff;
    exec(rre_pkg::OPC_CLEAR_CARRY, 8'h00, 6, 0);
    chk(16'(m.rf[FC]), 16'h007f);
    $display("test carry clear finished");
    sub_exit(16'h2000, 8'h18, 8'hb5);
    sub_exit(16'hffff, 8'h3c, 8'hc3);
    // A PC write and a second command while busy must both be ignored.
    m.rf[FE] = 8'h30;
    m.rf[FF] = 8'h00;
    m.stk[16'h3000] = 8'h5a;
    m.stk[16'h3001] = 8'h69;
    apb(1'b1, rre_pkg::ADDR_CMD, {24'h00_0000, rre_pkg::OPC_SUB_EXIT});
    apb(1'b1, rre_pkg::ADDR_PC, 32'h0000_beef);
    apb(1'b1, rre_pkg::ADDR_CMD, 32'h0000_c690);
    repeat (20) @(negedge pclk);
    chk(pc, 16'h5a69);
    rdc(rre_pkg::ADDR_CMD, 16'h00af);
    rdc(A_ST, 16'h0002);
    apb(1'b1, A_ST, 32'h0000_0006);
    apb(1'b1, rre_pkg::ADDR_PC, 32'h0000_1234);
    rdc(rre_pkg::ADDR_PC, 16'h1234);
    $display("test return finished");
    end_of_test();
  end
endmodule
